// ==== rcfrp_top.sv ====
// Receive cell FIFO read port: FIFO, read side pins, parity, cell flag and APB registers.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module rcfrp_top
    import rcfrp_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Write side from the cell processor.
    input  wire logic              push_valid,
    input  wire rcfrp_word_t       push_word,
    output logic                   push_ready,
    // Read port pins.
    input  wire logic              rx_read_en_n,
    input  wire logic              narrow_width_sel,
    input  wire logic              hiz_mode_sel,
    output logic      [WORD_W-1:0] rx_word_bus,
    output logic      [WORD_W-1:0] rx_word_bus_oe,
    output logic      [1:0]        rx_word_parity,
    output logic      [1:0]        rx_word_parity_oe,
    output logic                   rx_first_word_flag,
    output logic                   rx_first_word_flag_oe,
    output logic                   rx_cell_avail,
    output logic                   narrow_mode
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       rd_n;
    logic       narrow;
    logic       hiz;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
        end else begin
            sync1_reg <= {rx_read_en_n, narrow_width_sel, hiz_mode_sel};
            sync2_reg <= sync1_reg;
        end
    end
    assign rd_n   = sync2_reg[2];
    assign narrow = sync2_reg[1];
    assign hiz    = sync2_reg[0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0]       cfg_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] cells_reg;
    logic             setup_ph;

    assign setup_ph = psel && !penable;

    // Zero wait states: pready rises in the access phase.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cfg_reg <= CFG_RESET;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph && (paddr != CFG_OFS) && (paddr != STAT_OFS);
            if (setup_ph && !pwrite) begin
                unique case (paddr)
                    CFG_OFS:  prdata <= {27'h0, cfg_reg};
                    STAT_OFS: prdata <= {8'h0, cells_reg, 8'h0, count_reg};
                    default:  prdata <= 32'h0;
                endcase
            end
            if (psel && penable && pready && pwrite && paddr == CFG_OFS) begin
                cfg_reg <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // FIFO pointers
    // ------------------------------------------------------------
    logic [FIFO_DEPTH_LOG-1:0] wr_ptr_reg;
    logic [FIFO_DEPTH_LOG-1:0] rd_ptr_reg;
    logic                      do_push;
    logic                      do_pop;
    rcfrp_word_t               mem_q;
    logic [WCNT_W-1:0]         wcnt_reg;
    logic [WCNT_W-1:0]         cell_len;
    logic                      cell_end;
    logic                      stale_reg;

    assign cell_len = narrow ? CELL_W8_C : CELL_W16_C;
    assign do_push  = push_valid && push_ready;
    assign do_pop   = !rd_n && (count_reg != '0) && !stale_reg;
    assign cell_end = do_push && (wcnt_reg == cell_len - 6'h01);

    // Memory is read one word ahead so the popped word is ready at the pop edge.
    logic [FIFO_DEPTH_LOG-1:0] rd_addr_next;
    assign rd_addr_next = do_pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;

    rcfrp_mem #(.AW(FIFO_DEPTH_LOG)) u_mem (
        .ref_clk (ref_clk),
        .wr_en   (do_push),
        .wr_addr (wr_ptr_reg),
        .wr_data (push_word),
        .rd_addr (rd_addr_next),
        .rd_data (mem_q)
    );

    // A word written to the address being read reaches mem_q one edge late.
    // The pop waits that edge rather than hand out the old word.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stale_reg <= 1'b0;
        end else begin
            stale_reg <= do_push && (wr_ptr_reg == rd_addr_next);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            push_ready <= 1'b0;
            wcnt_reg   <= '0;
            cells_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg  <= count_reg + CNT_W'(do_push) - CNT_W'(do_pop);
            push_ready <= (count_reg + CNT_W'(do_push)) < CNT_W'(FIFO_DEPTH - 1);
            if (do_push) begin
                wcnt_reg <= cell_end ? '0 : wcnt_reg + 1'b1;
            end
            // A complete cell counts once its last word is stored.
            cells_reg <= cells_reg + CNT_W'(cell_end)
                         - CNT_W'(do_pop && mem_q.first && cells_reg != '0);
        end
    end

    // ------------------------------------------------------------
    // Read port outputs
    // ------------------------------------------------------------
    logic [1:0] par_next;
    logic [WORD_W-1:0] data_next;
    logic       odd;
    logic       drive;

    assign odd = cfg_reg[CFG_ODD_POS];
    // Narrow mode keeps the upper byte at zero.
    assign data_next = narrow ? {8'h0, mem_q.data[7:0]} : mem_q.data;

    always_comb begin
        if (cfg_reg[CFG_WHOLE_POS]) begin
            par_next = {(^data_next) ^ odd, 1'b0};
        end else begin
            par_next = {(^data_next[15:8]) ^ odd, (^data_next[7:0]) ^ odd};
        end
    end

    // Outputs are driven after a sampled low enable, or always without hiz mode.
    assign drive = !hiz || !rd_n;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_word_bus        <= '0;
            rx_word_parity     <= 2'h0;
            rx_first_word_flag <= 1'b0;
        end else if (do_pop) begin
            rx_word_bus        <= data_next;
            rx_word_parity     <= par_next;
            rx_first_word_flag <= mem_q.first;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_word_bus_oe        <= '0;
            rx_word_parity_oe     <= 2'h0;
            rx_first_word_flag_oe <= 1'b0;
        end else begin
            rx_word_bus_oe        <= {WORD_W{drive}};
            rx_word_parity_oe     <= {2{drive}};
            rx_first_word_flag_oe <= drive;
        end
    end

    // ------------------------------------------------------------
    // Cell available flag
    // ------------------------------------------------------------
    logic avail_reg;
    logic [CNT_W-1:0] count_after;

    assign count_after = count_reg - CNT_W'(do_pop);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            avail_reg <= 1'b0;
        end else if (cells_reg != '0 && !(cells_reg == 1 && do_pop && mem_q.first)) begin
            avail_reg <= 1'b1;
        end else if (cfg_reg[CFG_EMPTY_POS] ? count_after == '0
                                              : count_after <= LOW_WATER_C) begin
            avail_reg <= cfg_reg[CFG_DEFAV_POS];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_cell_avail <= 1'b0;
            narrow_mode   <= 1'b0;
        end else begin
            rx_cell_avail <= avail_reg ^ cfg_reg[CFG_AVLOW_POS];
            narrow_mode   <= narrow;
        end
    end

    a_pop_data: assert property (@(posedge ref_clk) disable iff (!rstn)
        do_pop |=> rx_word_bus == $past(data_next))
        else $error("popped word not presented");
    a_hold_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        !do_pop |=> $stable(rx_word_bus))
        else $error("bus changed without pop");
    a_hiz_off: assert property (@(posedge ref_clk) disable iff (!rstn)
        (hiz && rd_n) |=> !rx_first_word_flag_oe && rx_word_bus_oe == '0)
        else $error("driven while enable high in hiz mode");
    a_always_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
        !hiz |=> rx_word_parity_oe == 2'h3)
        else $error("not driven with hiz off");
    a_word_par: assert property (@(posedge ref_clk) disable iff (!rstn)
        (do_pop && cfg_reg[CFG_WHOLE_POS]) |=> rx_word_parity[0] == 1'b0)
        else $error("lower parity used in word mode");
    a_byte_par: assert property (@(posedge ref_clk) disable iff (!rstn)
        (do_pop && !cfg_reg[CFG_WHOLE_POS]) |=>
        rx_word_parity[0] == ((^rx_word_bus[7:0]) ^ $past(odd)))
        else $error("lower parity wrong");
    a_narrow_hi: assert property (@(posedge ref_clk) disable iff (!rstn)
        (do_pop && narrow) |=> rx_word_bus[15:8] == 8'h0)
        else $error("upper byte used in narrow mode");
    a_avail_pol: assert property (@(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> rx_cell_avail == ($past(avail_reg) ^ $past(cfg_reg[CFG_AVLOW_POS])))
        else $error("flag polarity wrong");
    a_avail_set: assert property (@(posedge ref_clk) disable iff (!rstn)
        (cells_reg != '0 && !do_pop) |=> avail_reg)
        else $error("flag low with cells stored");
endmodule : rcfrp_top
`default_nettype wire

// ==== rcfrp_pkg.sv ====
// Package of constants and carrier types for the receive cell FIFO read port.
package rcfrp_pkg;

    localparam int WORD_W         = 16;
    localparam int BYTE_W         = 8;
    localparam int CELL_BYTES     = 53;
    localparam int CELL_WORDS_16  = 27;
    localparam int CELL_WORDS_8   = 53;
    localparam int LOW_WATER      = 4;
    localparam int FIFO_DEPTH_LOG = 7;
    localparam int FIFO_DEPTH     = 128;
    localparam int CNT_W          = FIFO_DEPTH_LOG + 1;
    localparam int WCNT_W         = 6;

    localparam logic [CNT_W-1:0]  LOW_WATER_C  = 8'h04;
    localparam logic [WCNT_W-1:0] CELL_W16_C   = 6'h1b;
    localparam logic [WCNT_W-1:0] CELL_W8_C    = 6'h35;

    // APB register offsets.
    localparam logic [7:0] CFG_OFS    = 8'h00;
    localparam logic [7:0] STAT_OFS   = 8'h04;

    // Configuration field positions.
    localparam int CFG_ODD_POS     = 0;
    localparam int CFG_WHOLE_POS   = 1;
    localparam int CFG_EMPTY_POS   = 2;
    localparam int CFG_DEFAV_POS   = 3;
    localparam int CFG_AVLOW_POS   = 4;
    localparam logic [4:0] CFG_RESET = 5'h00;

    // Word pushed from the cell processor side.
    typedef struct packed {
        logic              first;
        logic [WORD_W-1:0] data;
    } rcfrp_word_t;

    // Driven bundle of the read port pins.
    typedef struct packed {
        logic              first;
        logic [1:0]        parity;
        logic [WORD_W-1:0] data;
    } rcfrp_pins_t;

endpackage : rcfrp_pkg

// ==== rcfrp_mem.sv ====
// Word memory of the receive cell FIFO with registered read data.
`timescale 1ns/1ps
`default_nettype none
module rcfrp_mem
    import rcfrp_pkg::*;
#(
    parameter int AW = FIFO_DEPTH_LOG
) (
    input  wire logic              ref_clk,
    input  wire logic              wr_en,
    input  wire logic [AW-1:0]     wr_addr,
    input  wire rcfrp_word_t       wr_data,
    input  wire logic [AW-1:0]     rd_addr,
    output var  rcfrp_word_t       rd_data
);
    rcfrp_word_t mem [0:(1<<AW)-1];

    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : rcfrp_mem
`default_nettype wire

// ==== rcfrp_reader.sv ====
// Model of the cell-layer device that reads words from the receive port.
`timescale 1ns/1ps
`default_nettype none
module rcfrp_reader
    import rcfrp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic       go,
    input  wire logic [6:0] n,
    input  wire logic       slow,
    input  wire logic       avail,
    output logic            rx_read_en_n,
    output logic            busy
);
    logic [6:0] left;
    logic       armed;

    // The slow pace leaves a high cycle between pops, so the port sees gaps mid-cell.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rx_read_en_n <= 1'b1;
            busy         <= 1'b0;
            armed        <= 1'b0;
            left         <= 7'h00;
        end else if (go && !busy) begin
            busy  <= 1'b1;
            armed <= 1'b0;
            left  <= n;
        end else if (busy) begin
            if (!armed) begin
                armed <= avail;
            end else if (left == 7'h00) begin
                rx_read_en_n <= 1'b1;
                busy         <= 1'b0;
            end else if (slow && !rx_read_en_n) begin
                rx_read_en_n <= 1'b1;
            end else begin
                rx_read_en_n <= 1'b0;
                left         <= left - 7'h01;
            end
        end
    end
endmodule : rcfrp_reader
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench of the receive cell FIFO read port.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rcfrp_pkg::*;
;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, push_valid, push_ready;
    logic rd_en_n, narrow, hiz, first, avail, nmode, go, slow, busy;
    logic [7:0] paddr, w_ctr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] bus, bus_oe, prev_bus;
    logic [1:0] par, par_oe;
    logic first_oe, e;
    logic [6:0] n;
    logic [4:0] cfg;
    rcfrp_word_t push_word;
    rcfrp_word_t exp_q[$];
    int n_mismatch, checked;

    rcfrp_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .push_valid(push_valid), .push_word(push_word),
        .push_ready(push_ready), .rx_read_en_n(rd_en_n), .narrow_width_sel(narrow),
        .hiz_mode_sel(hiz), .rx_word_bus(bus), .rx_word_bus_oe(bus_oe),
        .rx_word_parity(par), .rx_word_parity_oe(par_oe), .rx_first_word_flag(first),
        .rx_first_word_flag_oe(first_oe), .rx_cell_avail(avail), .narrow_mode(nmode));
    rcfrp_reader rdr_u (.ref_clk(ref_clk), .rstn(rstn), .go(go), .n(n), .slow(slow),
        .avail(avail ^ cfg[CFG_AVLOW_POS]), .rx_read_en_n(rd_en_n), .busy(busy));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic set_cfg(input logic [4:0] c);
        cfg = c;
        apb(1'b1, CFG_OFS, {27'h0, c});
        repeat (4) @(posedge ref_clk);
    endtask : set_cfg

    task automatic push(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            push_valid <= 1'b1;
            push_word <= {i == 0, w_ctr ^ 8'ha5, w_ctr};
            do @(posedge ref_clk); while (push_ready !== 1'b1);
            exp_q.push_back({i == 0, w_ctr ^ 8'ha5, w_ctr});
            w_ctr = w_ctr + 8'h01;
        end
        push_valid <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : push

    task automatic rd(input logic [6:0] cnt, input logic s);
        n <= cnt;
        slow <= s;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        do @(posedge ref_clk); while (busy === 1'b1);
        repeat (4) @(posedge ref_clk);
    endtask : rd

    // A new word shows as a change of the bus, so consecutive test words always differ.
    // Sampled on the falling edge, away from the edge that launches the outputs.
    always @(negedge ref_clk) begin : mon
        rcfrp_word_t w;
        logic [15:0] ed;
        if (rstn && bus !== prev_bus) begin
            prev_bus = bus;
            w = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            ed = narrow ? {8'h00, w.data[7:0]} : w.data;
            cmp(32'(bus), 32'(ed));
            cmp(32'(par), cfg[CFG_WHOLE_POS] ? {30'h0, ^ed ^ cfg[0], 1'b0} :
                {30'h0, ^ed[15:8] ^ cfg[0], ^ed[7:0] ^ cfg[0]});
            cmp(32'(first), 32'(w.first));
            cmp(32'({bus_oe, par_oe, first_oe}), 32'h7ffff);
        end
    end

    task automatic end_of_test;
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    initial begin
        {rstn, psel, penable, pwrite, push_valid, narrow, hiz, go, slow} = '0;
        {paddr, pwdata, push_word, n, cfg, prev_bus, n_mismatch, checked} = '0;
        w_ctr = 8'h01;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        cmp(32'(avail), 32'h0);
        apb(1'b0, CFG_OFS, 32'h0);
        cmp(r, 32'(CFG_RESET));
        apb(1'b0, 8'h08, 32'h0);
        cmp(32'(e), 32'h1);
        push(CELL_WORDS_16);
        cmp(32'(avail), 32'h1);
        apb(1'b0, STAT_OFS, 32'h0);
        cmp(r, {16'h0001, 16'(CELL_WORDS_16)});
        rd(7'd23, 1'b0);
        cmp(32'(avail), 32'h0);
        push(CELL_WORDS_16);
        rd(7'd31, 1'b1);
        cmp(32'(avail), 32'h0);
        hiz <= 1'b1;
        set_cfg(5'h07);
        cmp(32'({bus_oe, par_oe, first_oe}), 32'h0);
        push(CELL_WORDS_16);
        rd(7'd23, 1'b1);
        cmp(32'(avail), 32'h1);
        rd(7'd4, 1'b0);
        cmp(32'(avail), 32'h0);
        hiz <= 1'b0;
        narrow <= 1'b1;
        set_cfg(5'h01);
        cmp(32'(nmode), 32'h1);
        cmp(32'({bus_oe, par_oe, first_oe}), 32'h7ffff);
        push(CELL_WORDS_8);
        cmp(32'(avail), 32'h1);
        rd(7'd53, 1'b0);
        cmp(32'(exp_q.size()), 32'h0);
        set_cfg(5'h08);
        cmp(32'(avail), 32'h1);
        set_cfg(5'h10);
        cmp(32'(avail), 32'h1);
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
